// >>> nmdram_pkg.sv
// Package for the nibble-mode memory module controller: timing counts, sizes, states.
// Assumes a 100 MHz sys_clk.
package nmdram_pkg;
  // ****************************************
  // Geometry
  // ****************************************
  localparam int ADDR_W      = 10;
  localparam int DATA_W      = 8;
  localparam int WORD_COUNT  = 1048576;
  localparam int NIB_STEPS   = 4;
  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_NS          = 10;
  localparam int PAUSE_US        = 500;
  localparam int PAUSE_CYC       = (PAUSE_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int WAKE_CYCLES     = 8;
  localparam int REF_ROWS        = 512;
  localparam int REF_PERIOD_MS   = 8;
  localparam int REF_INTERVAL    = (REF_PERIOD_MS * 1000000 / REF_ROWS) / CLK_NS;
  localparam int RAS_PRE_NS      = 80;
  localparam int RAS_PRE_CYC     = (RAS_PRE_NS + CLK_NS - 1) / CLK_NS;
  localparam int RCD_NS          = 30;
  localparam int RCD_CYC         = (RCD_NS + CLK_NS - 1) / CLK_NS;
  localparam int CAS_LOW_NS      = 30;
  localparam int CAS_LOW_CYC     = (CAS_LOW_NS + CLK_NS - 1) / CLK_NS;
  localparam int CAS_PRE_NS      = 20;
  localparam int CAS_PRE_CYC     = (CAS_PRE_NS + CLK_NS - 1) / CLK_NS;
  localparam int RAS_LOW_NS      = 100;
  localparam int RAS_LOW_CYC     = (RAS_LOW_NS + CLK_NS - 1) / CLK_NS;
  localparam int CNT_W           = 16;
  // ****************************************
  // States
  // ****************************************
  typedef enum logic [3:0] {
    ST_PAUSE   = 4'h0,
    ST_WAKE    = 4'h1,
    ST_IDLE    = 4'h3,
    ST_ROW     = 4'h2,
    ST_COL     = 4'h6,
    ST_CASHI   = 4'h7,
    ST_RASHI   = 4'h5,
    ST_REFCAS  = 4'h4,
    ST_REFRAS  = 4'hc
  } nmdram_state_t;
endpackage : nmdram_pkg

// >>> nmdram_ctrl.sv
// Controller that drives the multiplexed-address, strobe-selected memory module.
// Assumes the user holds its request until accepted; module pins are outside the clock domain.
`timescale 1ns/1ps
module nmdram_ctrl
  import nmdram_pkg::*;
#(
  parameter int PAUSE_CYCLES = PAUSE_CYC,
  parameter int REF_CYCLES   = REF_INTERVAL
) (
  input  wire logic                sys_clk,
  input  wire logic                srst,
  input  wire logic                reqValid,
  output logic                     reqReady,
  input  wire logic                reqWrite,
  input  wire logic                reqNibble,
  input  wire logic [2*ADDR_W-1:0] reqAddr,
  input  wire logic [4*DATA_W-1:0] reqWdata,
  output logic                     rspValid,
  output logic [4*DATA_W-1:0]      rspRdata,
  output logic                     initDone,
  output logic                     rasN,
  output logic                     casN,
  output logic                     weN,
  output logic [ADDR_W-1:0]        memAddr,
  input  wire logic [DATA_W-1:0]   memDqIn,
  output logic [DATA_W-1:0]        memDqOut,
  output logic                     memDqOe
);
  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    nmdram_state_t      st;
    logic [CNT_W-1:0]   cnt;
    logic [CNT_W-1:0]   refCnt;
    logic               refPend;
    logic [3:0]         wake;
    logic [1:0]         nib;
    logic               last;
    logic               wr;
    logic               burst;
    logic [2*ADDR_W-1:0] addr;
    logic [4*DATA_W-1:0] wdata;
    logic [4*DATA_W-1:0] rdata;
    logic               rsp;
    logic               done;
    logic               ras;
    logic               cas;
    logic               we;
    logic [ADDR_W-1:0]  a;
    logic [DATA_W-1:0]  dq;
    logic               oe;
  } nmdram_regs_t;

  nmdram_regs_t s_q, s_d;
  logic [DATA_W-1:0] dqMeta_q, dqSync_q;

  // Two flops before any logic samples the bus
  always_ff @(posedge sys_clk) begin
    dqMeta_q <= memDqIn;
    dqSync_q <= dqMeta_q;
  end

  function automatic logic [DATA_W-1:0] pickByte(input logic [4*DATA_W-1:0] w, input logic [1:0] i);
    pickByte = w[i*DATA_W +: DATA_W];
  endfunction : pickByte

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    s_d = s_q;
    s_d.rsp = 1'b0;
    if (s_q.cnt != '0) s_d.cnt = s_q.cnt - 1'b1;
    // Refresh demand; a pending request is never dropped, set wins
    if (s_q.refCnt == '0) begin
      s_d.refCnt  = CNT_W'(REF_CYCLES - 1);
      s_d.refPend = 1'b1;
    end else begin
      s_d.refCnt = s_q.refCnt - 1'b1;
    end
    case (s_q.st)
      ST_PAUSE: begin
        if (s_q.cnt == '0) begin
          s_d.st = ST_WAKE;
        end
      end
      ST_WAKE: begin
        // Wake-up pulses are column-before-row refreshes, covering both start-up needs
        if (s_q.wake == 4'(WAKE_CYCLES)) begin
          s_d.st   = ST_IDLE;
          s_d.done = 1'b1;
        end else begin
          s_d.wake = s_q.wake + 4'h1;
          s_d.cas  = 1'b0;
          s_d.cnt  = CNT_W'(CAS_PRE_CYC);
          s_d.st   = ST_REFCAS;
        end
      end
      ST_IDLE: begin
        if (s_q.refPend) begin
          s_d.refPend = (s_q.refCnt == '0);
          s_d.cas     = 1'b0;
          s_d.cnt     = CNT_W'(CAS_PRE_CYC);
          s_d.st      = ST_REFCAS;
        end else if (reqValid) begin
          s_d.wr    = reqWrite;
          s_d.burst = reqNibble;
          s_d.addr  = reqAddr;
          s_d.wdata = reqWdata;
          s_d.nib   = 2'b00;
          s_d.a     = reqAddr[ADDR_W-1:0];
          s_d.ras   = 1'b0;
          s_d.we    = ~reqWrite;
          s_d.cnt   = CNT_W'(RCD_CYC);
          s_d.st    = ST_ROW;
        end
      end
      ST_REFCAS: begin
        if (s_q.cnt == '0) begin
          if (s_q.ras) begin
            s_d.ras = 1'b0;
            s_d.cnt = CNT_W'(RAS_LOW_CYC);
          end else begin
            s_d.ras = 1'b1;
            s_d.cas = 1'b1;
            s_d.cnt = CNT_W'(RAS_PRE_CYC);
            s_d.st  = ST_RASHI;
          end
        end
      end
      ST_ROW: begin
        s_d.a = s_q.addr[2*ADDR_W-1:ADDR_W];
        if (s_q.cnt == '0) begin
          s_d.cas = 1'b0;
          s_d.oe  = s_q.wr;
          s_d.dq  = pickByte(s_q.wdata, 2'b00);
          s_d.cnt = CNT_W'(CAS_LOW_CYC);
          s_d.st  = ST_COL;
        end
      end
      ST_COL: begin
        if (s_q.cnt == '0) begin
          if (!s_q.wr) begin
            s_d.rdata[s_q.nib*DATA_W +: DATA_W] = dqSync_q;
          end
          s_d.cas  = 1'b1;
          s_d.oe   = 1'b0;
          s_d.last = !s_q.burst || (s_q.nib == 2'(NIB_STEPS - 1));
          s_d.nib  = s_q.nib + 2'b01;
          s_d.cnt  = CNT_W'(CAS_PRE_CYC);
          s_d.st   = ST_CASHI;
        end
      end
      ST_CASHI: begin
        if (s_q.cnt == '0) begin
          if (s_q.last) begin
            s_d.ras = 1'b1;
            s_d.we  = 1'b1;
            s_d.rsp = ~s_q.wr;
            s_d.cnt = CNT_W'(RAS_PRE_CYC);
            s_d.st  = ST_RASHI;
          end else begin
            s_d.cas = 1'b0;
            s_d.oe  = s_q.wr;
            s_d.dq  = pickByte(s_q.wdata, s_q.nib);
            s_d.cnt = CNT_W'(CAS_LOW_CYC);
            s_d.st  = ST_COL;
          end
        end
      end
      ST_RASHI: begin
        if (s_q.cnt == '0) begin
          if (s_q.done) begin
            s_d.st = ST_IDLE;
          end else begin
            s_d.st = ST_WAKE;
          end
        end
      end
      default: s_d.st = ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      s_q        <= '0;
      s_q.st     <= ST_PAUSE;
      s_q.cnt    <= CNT_W'(PAUSE_CYCLES);
      s_q.refCnt <= CNT_W'(REF_CYCLES - 1);
      s_q.ras    <= 1'b1;
      s_q.cas    <= 1'b1;
      s_q.we     <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign reqReady = (s_q.st == ST_IDLE) && !s_q.refPend;
  assign rspValid = s_q.rsp;
  assign rspRdata = s_q.rdata;
  assign initDone = s_q.done;
  assign rasN     = s_q.ras;
  assign casN     = s_q.cas;
  assign weN      = s_q.we;
  assign memAddr  = s_q.a;
  assign memDqOut = s_q.dq;
  assign memDqOe  = s_q.oe;

  // ****************************************
  // Checks
  // ****************************************
  sequence casFall;
    $fell(casN);
  endsequence
  a_early_write_we: assert property (@(posedge sys_clk) disable iff (srst)
    casFall ##0 memDqOe |-> !weN) else $error("write data without write-enable");
  a_oe_cas_low: assert property (@(posedge sys_clk) disable iff (srst)
    memDqOe |-> !casN && !rasN) else $error("data driven outside column strobe");
  a_cbr_we_high: assert property (@(posedge sys_clk) disable iff (srst)
    $fell(rasN) && !casN |-> weN) else $error("refresh with write-enable low");
  a_pause_quiet: assert property (@(posedge sys_clk) disable iff (srst)
    s_q.st == ST_PAUSE |-> rasN && casN) else $error("strobes active in pause");
  a_ready_idle: assert property (@(posedge sys_clk) disable iff (srst)
    reqReady |-> initDone && rasN) else $error("ready before init or during row");
  a_row_before_col: assert property (@(posedge sys_clk) disable iff (srst)
    $fell(rasN) && casN |=> casN) else $error("column strobe too soon");
  a_ref_rate: assert property (@(posedge sys_clk) disable iff (srst)
    s_q.refCnt == '0 |=> s_q.refPend) else $error("refresh demand lost");
  a_nib_wrap: assert property (@(posedge sys_clk) disable iff (srst)
    $rose(casN) && s_q.nib == 2'b00 && s_q.burst |-> s_q.last) else $error("burst past four");
endmodule : nmdram_ctrl

// >>> nmdram_model.sv
// Behavioural model of the strobe-selected memory module.
// Assumes strobes, address and data come from the controller's registers.
`timescale 1ns/1ps
module nmdram_model
  import nmdram_pkg::*;
(
  input  wire logic              sys_clk,
  input  wire logic              rasN,
  input  wire logic              casN,
  input  wire logic              weN,
  input  wire logic [ADDR_W-1:0] memAddr,
  input  wire logic [DATA_W-1:0] memDqOut,
  input  wire logic              memDqOe,
  output logic      [DATA_W-1:0] memDqIn,
  output int                     cbrCount,
  output int                     clashCount
);
  // ****************************************
  // Storage and strobe decode
  // ****************************************
  logic [DATA_W-1:0]   mem [0:WORD_COUNT-1];
  logic [ADDR_W-1:0]   row, col;
  logic [1:0]          nib, top;
  logic                rd, wrPend, rasQ, drv;
  logic [DATA_W-1:0]   lastQ;
  logic [2*ADDR_W-1:0] cur;
  initial begin
    cbrCount = 0;
    clashCount = 0;
    rd = 1'b0;
    wrPend = 1'b0;
    rasQ = 1'b1;
    lastQ = 8'h00;
    nib = 2'h0;
  end
  // Row taken on the clock, not the strobe event, to dodge the same-edge address race
  always @(posedge sys_clk) begin
    if (!rasN && rasQ && casN) begin
      row = memAddr;
      nib = 2'h0;
    end else if (!rasN && rasQ && !rd) begin
      cbrCount++;
    end
    rasQ = rasN;
    if (wrPend && !casN) begin
      mem[cur] = memDqOut;
      if (!memDqOe) clashCount++;
      wrPend = 1'b0;
    end
    if (drv && memDqOe) clashCount++;
    lastQ = memDqIn;
  end
  always @(negedge casN) begin
    if (!rasN) begin
      if (nib == 2'h0) col = memAddr;
      top = {col[9], row[9]} + nib;
      cur = {top[1], col[8:0], top[0], row[8:0]};
      rd = weN;
      wrPend = !weN;
    end else begin
      rd = 1'b0;
      wrPend = 1'b0;
    end
  end
  always @(posedge casN) nib = nib + 2'h1;
  // Released bus toggles each cycle so a stale value never looks valid
  assign drv = !casN && rd;
  assign memDqIn = drv ? mem[cur] : ~lastQ;
endmodule : nmdram_model

// >>> nibble_mode_dram_module_port_bench.sv
// Self-checking bench for the memory controller against the module model.
// Assumes short pause and refresh intervals set through parameters.
`timescale 1ns/1ps
module nibble_mode_dram_module_port_bench;
  import nmdram_pkg::*;
  logic                sys_clk = 0, srst = 1, reqValid = 0, reqWrite = 0, reqNibble = 0;
  logic [2*ADDR_W-1:0] reqAddr = '0;
  logic [4*DATA_W-1:0] reqWdata = '0, got;
  logic                reqReady, rspValid, initDone, rasN, casN, weN, memDqOe;
  logic [4*DATA_W-1:0] rspRdata;
  logic [ADDR_W-1:0]   memAddr;
  logic [DATA_W-1:0]   memDqIn, memDqOut;
  int                  mismatches = 0, checksDone = 0, cycles = 0, cbrCount, clashCount, base;
  always #5 sys_clk = ~sys_clk;
  nmdram_ctrl #(.PAUSE_CYCLES(10), .REF_CYCLES(200)) u_nmdram_ctrl (.sys_clk(sys_clk), .srst(srst),
    .reqValid(reqValid), .reqReady(reqReady), .reqWrite(reqWrite), .reqNibble(reqNibble),
    .reqAddr(reqAddr), .reqWdata(reqWdata), .rspValid(rspValid), .rspRdata(rspRdata),
    .initDone(initDone), .rasN(rasN), .casN(casN), .weN(weN), .memAddr(memAddr),
    .memDqIn(memDqIn), .memDqOut(memDqOut), .memDqOe(memDqOe));
  nmdram_model u_nmdram_model (.sys_clk(sys_clk), .rasN(rasN), .casN(casN), .weN(weN),
    .memAddr(memAddr), .memDqOut(memDqOut), .memDqOe(memDqOe), .memDqIn(memDqIn),
    .cbrCount(cbrCount), .clashCount(clashCount));
  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] seen);
    checksDone++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic access(input logic wr, input logic nb, input logic [19:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    // Let an edge pass so reqValid is never lowered and raised in one step
    @(posedge sys_clk);
    #1;
    reqValid  = 1'b1;
    reqWrite  = wr;
    reqNibble = nb;
    reqAddr   = a;
    reqWdata  = wd;
    while (reqReady !== 1'b1 && n < 5000) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    check("reqReady", 32'h1, {31'h0, reqReady});
    @(posedge sys_clk);
    #1;
    reqValid = 1'b0;
    n = 0;
    if (!wr) begin
      while (rspValid !== 1'b1 && n < 100) begin
        @(posedge sys_clk);
        #1;
        n++;
      end
      check("rspValid", 32'h1, {31'h0, rspValid});
      got = rspRdata;
    end
  endtask : access
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checksDone, mismatches);
    if (mismatches == 0 && checksDone > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : finish_test
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_init();
    int n;
    n = 0;
    check("idle strobes", 32'h3, {30'h0, rasN, casN});
    check("idle ready", 32'h0, {30'h0, reqReady, memDqOe});
    @(posedge sys_clk); #1;
    srst = 1'b0;
    while (initDone !== 1'b1 && n < 2000) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    check("init done", 32'h1, {31'h0, initDone});
    check("wake cycles", 32'h1, {31'h0, cbrCount >= 8});
  endtask : t_init
  task automatic t_single();
    access(1'b1, 1'b0, {10'h155, 10'h2aa}, 32'h5a);
    access(1'b1, 1'b0, {10'h2aa, 10'h155}, 32'ha5);
    access(1'b0, 1'b0, {10'h155, 10'h2aa}, 32'h0);
    check("single read", 32'h5a, {24'h0, got[7:0]});
    access(1'b0, 1'b0, {10'h2aa, 10'h155}, 32'h0);
    check("swapped read", 32'ha5, {24'h0, got[7:0]});
  endtask : t_single
  task automatic t_nibble();
    access(1'b1, 1'b1, {10'h0ab, 10'h0cd}, 32'h44332211);
    access(1'b0, 1'b1, {10'h0ab, 10'h0cd}, 32'h0);
    check("nibble read", 32'h44332211, got);
    access(1'b0, 1'b0, {10'h0ab, 10'h2cd}, 32'h0);
    check("row top step", 32'h22, {24'h0, got[7:0]});
    access(1'b0, 1'b0, {10'h2ab, 10'h0cd}, 32'h0);
    check("col top step", 32'h33, {24'h0, got[7:0]});
    access(1'b0, 1'b1, {10'h0ab, 10'h2cd}, 32'h0);
    check("nibble wrap", 32'h11443322, got);
  endtask : t_nibble
  task automatic t_refresh();
    base = cbrCount;
    repeat (1000) @(posedge sys_clk);
    #1;
    check("refresh rate", 32'h1, {31'h0, (cbrCount - base) >= 4});
    check("bus clash", 32'h0, clashCount);
  endtask : t_refresh
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      finish_test();
    end
  end
  initial begin
    repeat (15) @(posedge sys_clk);
    #1;
    t_init();
    t_single();
    t_nibble();
    t_refresh();
    finish_test();
  end
endmodule : nibble_mode_dram_module_port_bench
